// [core/smsp_core.v]
// Operation
// RULE_01: Full-duplex four-wire serial port on data out, data in, clock and select.
// RULE_02: Master or slave role chosen by the master enable bit.
// RULE_03: Master bit rate never above half the system clock.
// RULE_04: External master keeps full-duplex slave rate at or below clock/10.
// RULE_05: Send-only external master may reach clock/2 with synchronous signals.
// RULE_06: Detect another master starting a transfer while this unit is master.
// RULE_07: Active-low select chooses which slave joins a transfer.
// RULE_08: Master drives MOSI; slave only reads it.
// RULE_09: Both data lines shift most significant bit first.
// RULE_10: Selected slave drives MISO; master samples it.
// RULE_11: Unselected slave leaves MISO undriven.
// RULE_12: Only master drives SCK; slave times data from it.
// RULE_13: Select is an input: selects a slave, disables a master.
// RULE_14: External master holds select low for a whole transfer.
// RULE_15: Transfer end sets a done flag that software alone clears.
// RULE_16: Data write while busy is dropped and flags a write collision.
// RULE_17: Select low in master role flags mode fault and clears both enables.
// RULE_18: Master frame size field selects one to eight bits; slave ignores it.
// RULE_19: After reset unit disabled, flags clear, MISO undriven.
`timescale 1ns/1ps
`default_nettype none
`include "smsp_defines.vh"

module smsp_core (
    // Clock, reset, enable
    input  wire                 ref_clk_in,
    input  wire                 rst_n_in,
    input  wire                 ce_in,
    // Register port
    input  wire [`SMSP_AW-1:0]  addr_in,
    input  wire [`SMSP_DW-1:0]  wdata_in,
    input  wire                 wr_in,
    input  wire                 rd_in,
    output reg  [`SMSP_DW-1:0]  rdata_out,
    output reg                  irq_out,
    // Serial clock pin
    input  wire                 sck_in,
    output reg                  sck_out,
    output reg                  sck_oe_out,
    // Master-out data pin
    input  wire                 mosi_in,
    output reg                  mosi_out,
    output reg                  mosi_oe_out,
    // Master-in data pin
    input  wire                 miso_in,
    output reg                  miso_out,
    output reg                  miso_oe_out,
    // Select pin
    input  wire                 nss_n_in
);

    localparam ST_IDLE = 1'b0;
    localparam ST_RUN  = 1'b1;

    // Flags: done, write collision, mode fault, overrun
    reg        unit_enable_bit;
    reg        master_enable_bit;
    reg [3:0]  flags;
    reg [3:0]  mask;
    reg        cpha;
    reg        cpol;
    reg [2:0]  frame_size_field;
    reg [7:0]  rate;
    reg [7:0]  rx_buf;
    reg        rx_unread;
    reg [7:0]  shreg;
    reg [3:0]  edge_cnt;
    reg [2:0]  bit_cnt;
    reg [7:0]  div;
    reg        state;
    reg        sck_d;
    reg        nss_d;

    wire [3:0] pins_s;
    wire       sck_s;
    wire       mosi_s;
    wire       miso_s;
    wire       nss_s;

    function [7:0] low_mask;
        input [2:0] f;
        begin
            low_mask = 8'hFF >> (3'h7 - f);
        end
    endfunction

    function [3:0] last_edge;
        input [2:0] f;
        begin
            last_edge = {f, 1'b1};
        end
    endfunction

    function is_reg;
        input [`SMSP_AW-1:0] a;
        input [`SMSP_AW-1:0] r;
        begin
            is_reg = (a == r);
        end
    endfunction

    smsp_sync #(
        .W   (`SMSP_SYNC_W),
        .RST (`SMSP_RST_PINS)
    ) u_sync (
        .ref_clk_in (ref_clk_in),
        .rst_n_in   (rst_n_in),
        .ce_in      (ce_in),
        .async_in   ({sck_in, mosi_in, miso_in, nss_n_in}),
        .sync_out   (pins_s)
    );

    assign sck_s  = pins_s[3];
    assign mosi_s = pins_s[2];
    assign miso_s = pins_s[1];
    assign nss_s  = pins_s[0];

    wire mode_m  = unit_enable_bit & master_enable_bit; // RULE_02
    wire mode_s  = unit_enable_bit & ~master_enable_bit; // RULE_02
    wire sel     = ~nss_s; // RULE_07
    wire fault   = mode_m & sel; // RULE_06 RULE_13 RULE_17
    wire mrun    = (state == ST_RUN);
    wire m_tick  = mrun & (div == 8'h00);
    // Slave edges only while selected; rate limits on the far side keep this valid
    wire s_edge  = mode_s & sel & (sck_s ^ sck_d); // RULE_12 RULE_04 RULE_05
    wire lead    = mrun ? (sck_out == cpol) : (sck_d == cpol);
    wire go      = m_tick | s_edge;
    wire samp    = go & (lead ^ cpha);
    wire drv     = go & ~(lead ^ cpha);
    wire [2:0] top = mode_m ? frame_size_field : 3'h7; // RULE_18
    wire [7:0] sh_next = {shreg[6:0], mrun ? miso_s : mosi_s}; // RULE_09 RULE_10
    wire m_last  = m_tick & ~lead & (edge_cnt == last_edge(frame_size_field)); // RULE_18
    wire s_end   = mode_s & nss_s & ~nss_d; // RULE_14
    wire busy    = mrun | (mode_s & sel);
    wire dwr     = wr_in & is_reg(addr_in, `SMSP_ADDR_DATA);
    wire drd     = rd_in & is_reg(addr_in, `SMSP_ADDR_DATA);
    wire cwr     = wr_in & is_reg(addr_in, `SMSP_ADDR_CTRL);
    wire finish  = m_last | s_end;
    wire start   = dwr & mode_m & ~mrun & ~fault;
    wire write_collision_flag_ev = dwr & busy; // RULE_16
    wire ovr_ev  = finish & rx_unread;
    wire [7:0] rx_word = (samp ? sh_next : shreg) & low_mask(top);
    wire [3:0] set_ev = {finish, write_collision_flag_ev, fault, ovr_ev};
    wire [3:0] clr_ev = cwr ? wdata_in[`SMSP_B_DONE:`SMSP_B_OVRN] : 4'h0;
    wire [3:0] next_flags = (flags & ~clr_ev) | set_ev;

    // Enables; a mode fault overrides a software write in the same cycle
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            unit_enable_bit   <= 1'b0; // RULE_19
            master_enable_bit <= 1'b0;
        end else if (ce_in) begin
            if (fault) begin
                unit_enable_bit   <= 1'b0; // RULE_17
                master_enable_bit <= 1'b0;
            end else if (cwr) begin
                unit_enable_bit   <= wdata_in[`SMSP_B_UEN];
                master_enable_bit <= wdata_in[`SMSP_B_MEN];
            end
        end
    end

    // Sticky flags: a set in the clearing cycle wins
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            flags <= `SMSP_RST_FLAGS; // RULE_19
        end else if (ce_in) begin
            flags <= next_flags; // RULE_15
        end
    end

    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mask <= `SMSP_RST_MASK;
        end else if (ce_in && wr_in && is_reg(addr_in, `SMSP_ADDR_MASK)) begin
            mask <= wdata_in[`SMSP_B_DONE:`SMSP_B_OVRN];
        end
    end

    // Clock shape should only change with the unit disabled
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cpha             <= 1'b0;
            cpol             <= 1'b0;
            frame_size_field <= `SMSP_RST_FSIZE;
        end else if (ce_in && wr_in && is_reg(addr_in, `SMSP_ADDR_CFG)) begin
            cpha             <= wdata_in[`SMSP_B_CPHA];
            cpol             <= wdata_in[`SMSP_B_CPOL];
            frame_size_field <= wdata_in[`SMSP_F_FS_HI:`SMSP_F_FS_LO];
        end
    end

    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rate <= `SMSP_RST_RATE;
        end else if (ce_in && wr_in && is_reg(addr_in, `SMSP_ADDR_RATE)) begin
            rate <= wdata_in;
        end
    end

    // Master sequencer
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= ST_IDLE;
        end else if (ce_in) begin
            case (state)
                ST_IDLE: begin
                    if (start) begin
                        state <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (fault || !mode_m || m_last) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Half-period divider: reload of rate gives rate+1 cycles per half period
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div <= 8'h00;
        end else if (ce_in) begin
            if (start || m_tick) begin
                div <= rate + `SMSP_MIN_HALF - 8'h01; // RULE_03
            end else if (mrun) begin
                div <= div - 8'h01;
            end
        end
    end

    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            edge_cnt <= 4'h0;
        end else if (ce_in) begin
            if (start) begin
                edge_cnt <= 4'h0;
            end else if (m_tick) begin
                edge_cnt <= edge_cnt + 4'h1;
            end
        end
    end

    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bit_cnt <= 3'h0;
        end else if (ce_in) begin
            if (start || (mode_s && !sel)) begin
                bit_cnt <= 3'h0;
            end else if (samp) begin
                bit_cnt <= bit_cnt + 3'h1;
            end
        end
    end

    // Shift register: loaded only while idle
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            shreg <= 8'h00;
        end else if (ce_in) begin
            if (dwr && !busy) begin
                shreg <= wdata_in; // RULE_16
            end else if (samp) begin
                shreg <= sh_next; // RULE_09
            end
        end
    end

    // Receive buffer keeps the older word on overrun
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_buf    <= 8'h00;
            rx_unread <= 1'b0;
        end else if (ce_in) begin
            if (finish && !rx_unread) begin
                rx_buf    <= rx_word;
                rx_unread <= 1'b1;
            end else if (drd) begin
                rx_unread <= 1'b0;
            end
        end
    end

    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sck_d <= 1'b0;
            nss_d <= 1'b1;
        end else if (ce_in) begin
            sck_d <= sck_s;
            nss_d <= nss_s;
        end
    end

    // Serial clock out: toggles per half period, idles at polarity
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sck_out    <= 1'b0;
            sck_oe_out <= 1'b0;
        end else if (ce_in) begin
            sck_oe_out <= mode_m & ~fault; // RULE_12
            if (!mrun || fault) begin
                sck_out <= cpol;
            end else if (m_tick) begin
                sck_out <= ~sck_out; // RULE_03
            end
        end
    end

    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mosi_out    <= 1'b0;
            mosi_oe_out <= 1'b0;
        end else if (ce_in) begin
            mosi_oe_out <= mode_m & ~fault; // RULE_08 RULE_01
            if (start) begin
                mosi_out <= wdata_in[frame_size_field]; // RULE_09
            end else if (drv && mrun) begin
                mosi_out <= shreg[frame_size_field]; // RULE_09
            end
        end
    end

    // Slave output: first bit ready at selection, later bits on drive edges
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            miso_out    <= 1'b0;
            miso_oe_out <= 1'b0; // RULE_19
        end else if (ce_in) begin
            miso_oe_out <= mode_s & sel; // RULE_11 RULE_10
            if (mode_s && sel && nss_d) begin
                miso_out <= shreg[7]; // RULE_09
            end else if (drv && !mrun) begin
                miso_out <= shreg[7];
            end
        end
    end

    // Read data stand in the cycle after the strobe only
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_out <= 8'h00;
        end else if (ce_in) begin
            rdata_out <= 8'h00;
            if (rd_in) begin
                case (addr_in)
                    `SMSP_ADDR_CTRL: rdata_out <= {flags, busy, sel, master_enable_bit, unit_enable_bit};
                    `SMSP_ADDR_CFG:  rdata_out <= {cpha, cpol, bit_cnt, frame_size_field};
                    `SMSP_ADDR_RATE: rdata_out <= rate;
                    `SMSP_ADDR_DATA: rdata_out <= rx_buf;
                    `SMSP_ADDR_MASK: rdata_out <= {mask, 4'h0};
                    default:         rdata_out <= 8'h00;
                endcase
            end
        end
    end

    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_out <= 1'b0;
        end else if (ce_in) begin
            irq_out <= |(next_flags & mask); // RULE_15
        end
    end

endmodule // smsp_core

`default_nettype wire

// [pkg/smsp_defines.vh]
`ifndef SMSP_DEFINES_VH
`define SMSP_DEFINES_VH

// Register port geometry
`define SMSP_DW        8
`define SMSP_AW        3

// Register offsets
`define SMSP_ADDR_CTRL 3'h0
`define SMSP_ADDR_CFG  3'h1
`define SMSP_ADDR_RATE 3'h2
`define SMSP_ADDR_DATA 3'h3
`define SMSP_ADDR_MASK 3'h4

// Control/status bit positions
`define SMSP_B_DONE    7
`define SMSP_B_WRITE_COLLISION_FLAG    6
`define SMSP_B_MODE_FAULT_FLAG    5
`define SMSP_B_OVRN    4
`define SMSP_B_BUSY    3
`define SMSP_B_SEL     2
`define SMSP_B_MEN     1
`define SMSP_B_UEN     0

// Configuration bit positions
`define SMSP_B_CPHA    7
`define SMSP_B_CPOL    6
`define SMSP_F_BC_HI   5
`define SMSP_F_BC_LO   3
`define SMSP_F_FS_HI   2
`define SMSP_F_FS_LO   0

// Reset values
`define SMSP_RST_FSIZE 3'h7
`define SMSP_RST_RATE  8'h00
`define SMSP_RST_FLAGS 4'h0
`define SMSP_RST_MASK  4'h0
`define SMSP_RST_PINS  4'h1

// Timing: shortest half period of the master serial clock, in clock cycles
`define SMSP_MIN_HALF  8'h01
// Pin synchroniser width, one bit per synchronised pin
`define SMSP_SYNC_W    4

`endif

// [core/smsp_sync.v]
`timescale 1ns/1ps
`default_nettype none

module smsp_sync #(
    parameter W = 4,
    parameter [W-1:0] RST = {W{1'b0}}
) (
    // Clock, reset, enable
    input  wire         ref_clk_in,
    input  wire         rst_n_in,
    input  wire         ce_in,
    // Pins
    input  wire [W-1:0] async_in,
    output reg  [W-1:0] sync_out
);

    reg [W-1:0] meta;

    // First stage feeds the second stage only
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta     <= RST;
            sync_out <= RST;
        end else if (ce_in) begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule // smsp_sync

`default_nettype wire

// [test/smsp_core_properties.sv]
`timescale 1ns/1ps
`default_nettype none
`include "smsp_defines.vh"
module smsp_core_chk (
    // Clock and reset
    input wire logic                ref_clk_in,
    input wire logic                rst_n_in,
    input wire logic                ce_in,
    // Register port
    input wire logic [`SMSP_AW-1:0] addr_in,
    input wire logic [`SMSP_DW-1:0] wdata_in,
    input wire logic                wr_in,
    input wire logic                rd_in,
    input wire logic [`SMSP_DW-1:0] rdata_out,
    input wire logic                irq_out,
    // Serial pins
    input wire logic                sck_in,
    input wire logic                sck_out,
    input wire logic                sck_oe_out,
    input wire logic                mosi_in,
    input wire logic                mosi_out,
    input wire logic                mosi_oe_out,
    input wire logic                miso_in,
    input wire logic                miso_out,
    input wire logic                miso_oe_out,
    input wire logic                nss_n_in
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    logic [7:0] rate_q;
    logic [7:0] gap;
    logic       last_sck;
    // Cycles since the last serial clock toggle, saturating
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rate_q <= 8'h00;
            gap <= 8'h00;
            last_sck <= 1'b0;
        end else begin
            if (wr_in && ce_in && addr_in == `SMSP_ADDR_RATE)
                rate_q <= wdata_in;
            last_sck <= sck_out;
            gap <= (sck_out != last_sck) ? 8'h00 : ((gap == 8'hFF) ? gap : gap + 8'h01);
        end
    end
    chk_rate_floor: assert property (sck_oe_out && sck_out != last_sck |-> gap >= rate_q)
        else $error("serial clock toggled too early");
    chk_mosi_owner: assert property (mosi_oe_out == sck_oe_out)
        else $error("data out drive differs from clock drive");
    chk_role_excl: assert property (sck_oe_out |-> !miso_oe_out)
        else $error("master drives slave data line");
    chk_miso_float: assert property (miso_oe_out |-> !$past(nss_n_in, 3))
        else $error("slave data driven while not selected");
    chk_irq_clear: assert property ($fell(irq_out) |-> $past(wr_in) || $past(wr_in, 2))
        else $error("interrupt dropped without a write");
    chk_fault_off: assert property ($fell(nss_n_in) && sck_oe_out |-> ##[1:6] !sck_oe_out)
        else $error("master stays on with select low");
    chk_role_up: assert property ($rose(sck_oe_out) |->
        $past(wr_in && addr_in == `SMSP_ADDR_CTRL) || $past(wr_in && addr_in == `SMSP_ADDR_CTRL, 2))
        else $error("master role without control write");
    chk_reset_quiet: assert property (@(posedge ref_clk_in) disable iff (1'b0) !rst_n_in |->
        !(irq_out || sck_oe_out || mosi_oe_out || miso_oe_out) && rdata_out == 8'h00)
        else $error("outputs active in reset");
endmodule // smsp_core_chk
bind smsp_core smsp_core_chk u_smsp_core_chk (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out),
    .sck_in(sck_in), .sck_out(sck_out), .sck_oe_out(sck_oe_out), .mosi_in(mosi_in),
    .mosi_out(mosi_out), .mosi_oe_out(mosi_oe_out), .miso_in(miso_in), .miso_out(miso_out),
    .miso_oe_out(miso_oe_out), .nss_n_in(nss_n_in));
`default_nettype wire

// [test/smsp_far_slave.sv]
`timescale 1ns/1ps
`default_nettype none
module smsp_far_slave (
    // Serial pins
    input  wire logic       sck_in,
    input  wire logic       mosi_in,
    input  wire logic       cs_n_in,
    output logic            miso_out,
    // Data
    input  wire logic [7:0] tx_in,
    output logic [7:0]      rx_out
);
    logic [7:0] shreg = 8'h00;
    always @(negedge cs_n_in)
        shreg = tx_in;
    always @(posedge sck_in)
        if (!cs_n_in)
            rx_out <= {rx_out[6:0], mosi_in};
    always @(negedge sck_in)
        if (!cs_n_in)
            shreg <= {shreg[6:0], 1'b0};
    // No pull on the line, so a released line shows the inverse of its last bit
    assign miso_out = cs_n_in ? ~shreg[7] : shreg[7];
endmodule // smsp_far_slave
`default_nettype wire

// [test/tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "smsp_defines.vh"
module tb;
    logic       clk = 1'b0;
    logic       rst_n = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic       dev_nss_n = 1'b1;
    logic       m_sck = 1'b0;
    logic       m_mosi = 1'b0;
    logic       part_cs_n = 1'b1;
    int         failures = 0;
    int         samples_checked = 0;
    wire  [7:0] rdata;
    wire  [7:0] part_rx;
    wire        irq, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, part_miso;
    wire        sck_w = sck_oe ? sck_o : m_sck;
    wire        mosi_w = mosi_oe ? mosi_o : m_mosi;
    wire        miso_w = miso_oe ? miso_o : part_miso;
    always #5 clk = ~clk;
    smsp_core u_smsp_core (
        .ref_clk_in(clk), .rst_n_in(rst_n), .ce_in(1'b1), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .irq_out(irq), .sck_in(sck_w), .sck_out(sck_o),
        .sck_oe_out(sck_oe), .mosi_in(mosi_w), .mosi_out(mosi_o), .mosi_oe_out(mosi_oe),
        .miso_in(miso_w), .miso_out(miso_o), .miso_oe_out(miso_oe), .nss_n_in(dev_nss_n));
    smsp_far_slave u_smsp_far_slave (
        .sck_in(sck_w), .mosi_in(mosi_w), .cs_n_in(part_cs_n), .miso_out(part_miso),
        .tx_in(8'hA5), .rx_out(part_rx));
    task automatic results;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(rdata, exp);
    endtask
    task automatic wait_irq(input logic lvl);
        int n;
        n = 0;
        #1;
        while (irq !== lvl && n < 1000) begin
            @(posedge clk);
            #1;
            n++;
        end
        check({7'h00, irq}, {7'h00, lvl});
    endtask
    // Bench as external master; hp clocks per half bit: 5 for full duplex, 1 for send only
    task automatic ext_xfer(input logic [7:0] d, input int hp, output logic [7:0] r);
        @(posedge clk);
        dev_nss_n <= 1'b0;
        for (int i = 7; i >= 0; i--) begin
            m_mosi <= d[i];
            repeat (hp) @(posedge clk);
            m_sck <= 1'b1;
            r[i] = miso_w;
            repeat (hp) @(posedge clk);
            m_sck <= 1'b0;
        end
        repeat (hp) @(posedge clk);
        dev_nss_n <= 1'b1;
        m_mosi <= ~m_mosi;
        repeat (6) @(posedge clk);
    endtask
    initial begin
        #100us;
        failures++;
        results;
    end
    initial begin
        logic [7:0] m;
        logic [7:0] r;
        rst_n <= 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rreg(`SMSP_ADDR_CTRL, 8'h00);
        rreg(`SMSP_ADDR_CFG, 8'h07);
        rreg(`SMSP_ADDR_RATE, 8'h00);
        rreg(`SMSP_ADDR_MASK, 8'h00);
        wreg(3'h6, 8'hFF);
        rreg(3'h6, 8'h00);
        wreg(`SMSP_ADDR_CTRL, 8'h03);
        wreg(`SMSP_ADDR_RATE, 8'h03);
        wreg(`SMSP_ADDR_MASK, 8'h80);
        for (int f = 7; f >= 0; f--) begin
            m = 8'hFF >> (7 - f);
            wreg(`SMSP_ADDR_CFG, {5'h00, f[2:0]});
            part_cs_n <= 1'b0;
            wreg(`SMSP_ADDR_DATA, 8'h3C);
            wreg(`SMSP_ADDR_DATA, 8'hFF);
            wait_irq(1'b1);
            rreg(`SMSP_ADDR_CTRL, 8'hC3);
            rreg(`SMSP_ADDR_DATA, 8'hA5 >> (7 - f));
            check(part_rx & m, 8'h3C & m);
            part_cs_n <= 1'b1;
            wreg(`SMSP_ADDR_CTRL, 8'hC3);
            wait_irq(1'b0);
        end
        // Slave role; frame size is still one bit and must be ignored
        wreg(`SMSP_ADDR_MASK, 8'h00);
        wreg(`SMSP_ADDR_CTRL, 8'h01);
        wreg(`SMSP_ADDR_DATA, 8'h96);
        ext_xfer(8'h5A, 5, r);
        check(r, 8'h96);
        rreg(`SMSP_ADDR_DATA, 8'h5A);
        rreg(`SMSP_ADDR_CTRL, 8'h81);
        wait_irq(1'b0);
        wreg(`SMSP_ADDR_MASK, 8'h80);
        repeat (2) @(posedge clk);
        wait_irq(1'b1);
        wreg(`SMSP_ADDR_CTRL, 8'h81);
        // Send-only external master at the fastest legal rate; returned bits ignored
        ext_xfer(8'hC3, 1, r);
        rreg(`SMSP_ADDR_DATA, 8'hC3);
        wreg(`SMSP_ADDR_CTRL, 8'h81);
        // Another master grabs the bus once this unit drives the clock
        wreg(`SMSP_ADDR_MASK, 8'h20);
        wreg(`SMSP_ADDR_CTRL, 8'h03);
        repeat (2) @(posedge clk);
        dev_nss_n <= 1'b0;
        repeat (8) @(posedge clk);
        rreg(`SMSP_ADDR_CTRL, 8'h24);
        wait_irq(1'b1);
        @(posedge clk);
        dev_nss_n <= 1'b1;
        wreg(`SMSP_ADDR_CTRL, 8'h20);
        rreg(`SMSP_ADDR_CTRL, 8'h00);
        results;
    end
endmodule // tb
`default_nettype wire
